// file: rtl/atc_pkg.sv
`default_nettype none
package atc_pkg;
    localparam int NUM_CH  = 4;
    localparam int NUM_LVL = 5;
    localparam int SMP_W   = 8;
    localparam int REC_LEN = 8;
    localparam int IDX_W   = 3;
    localparam int NUM_LOG = 16;
    localparam int AVG_W   = 17;
    localparam int SH_W    = 5;
    localparam logic [AVG_W-1:0] AVG_CNT_MIN     = 17'h00002;
    localparam logic [AVG_W-1:0] AVG_CNT_MAX     = 17'h186a0;
    localparam logic [15:0]      SGL_CNT_RST     = 16'h0001;
    // Limit held in microseconds per division
    localparam logic [31:0]      ROLL_LIM_RST_US = 32'h0007a120;
    localparam logic [31:0]      HOLDOFF_RST     = 32'h00000000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int AUTO_TRIG_NS  = 100000;
    localparam int AUTO_TRIG_CYC = AUTO_TRIG_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {kind_refresh = 2'h0, kind_average = 2'h1, kind_envelope = 2'h2} atc_kind_e;
    typedef enum logic [1:0] {arith_off = 2'h0, arith_env = 2'h1, arith_avg = 2'h2} atc_arith_e;
    typedef enum logic [1:0] {dec_sample = 2'h0, dec_peak = 2'h1, dec_hres = 2'h2} atc_dec_e;
    typedef enum logic [1:0] {interp_linear = 2'h0, sinc_curve_interp = 2'h1,
                              sample_hold_interp = 2'h2} atc_interp_e;
    typedef enum logic [3:0] {src_analog1 = 4'h0, src_analog2 = 4'h1, src_analog3 = 4'h2, src_analog4 = 4'h3,
                              front_panel_trig_input = 4'h4, src_power_line = 4'h5,
                              serial_decoder_one = 4'h6, serial_decoder_two = 4'h7,
                              logic_channels = 4'h8} atc_src_e;
    typedef enum logic [2:0] {tt_edge = 3'h0, tt_width = 3'h1, tt_video = 3'h2, tt_bus = 3'h3,
                              tt_pattern = 3'h4, tt_line = 3'h5, tt_transition = 3'h6,
                              tt_runt = 3'h7} atc_ttype_e;
    typedef enum logic [1:0] {slope_rise = 2'h0, slope_fall = 2'h1, slope_either = 2'h2} atc_slope_e;
    typedef enum logic [1:0] {st_idle = 2'h0, st_armed = 2'h1, st_capt = 2'h3} atc_state_e;

    typedef struct packed {
        atc_kind_e                      acquisition_kind_select;
        atc_arith_e                     multi_acquisition_arith;
        logic                           peak_capture_switch;
        logic                           high_res_switch;
        logic [15:0]                    single_run_count;
        logic [AVG_W-1:0]               averaging_count;
        logic                           auto_roll;
        logic [31:0]                    scroll_timebase_limit;
        atc_interp_e                    interp_select;
        logic                           trig_auto;
        atc_src_e                       trig_src;
        logic [3:0]                     logic_sel;
        atc_ttype_e                     trig_type;
        logic                           holdoff_on;
        logic [31:0]                    holdoff_cyc;
        atc_slope_e                     slope;
        logic [NUM_LVL-1:0][SMP_W-1:0]  level;
    } atc_cfg_s;

    localparam atc_cfg_s CFG_RST = '{
        acquisition_kind_select: kind_refresh, multi_acquisition_arith: arith_off,
        peak_capture_switch: 1'b0, high_res_switch: 1'b0, single_run_count: SGL_CNT_RST,
        averaging_count: AVG_CNT_MIN, auto_roll: 1'b0, scroll_timebase_limit: ROLL_LIM_RST_US,
        interp_select: sinc_curve_interp, trig_auto: 1'b1, trig_src: src_analog1, logic_sel: 4'h0,
        trig_type: tt_edge, holdoff_on: 1'b0, holdoff_cyc: HOLDOFF_RST, slope: slope_rise,
        level: '0};

    typedef struct packed {
        logic                          valid;
        logic [NUM_CH-1:0][SMP_W-1:0]  ch;
        logic [SMP_W-1:0]              ext;
        logic                          line;
        logic [1:0]                    sbus;
        logic [NUM_LOG-1:0]            logic_in;
    } atc_smp_s;

    typedef struct packed {
        logic                          valid;
        logic [IDX_W-1:0]              idx;
        logic [NUM_CH-1:0][SMP_W-1:0]  lo;
        logic [NUM_CH-1:0][SMP_W-1:0]  hi;
    } atc_res_s;
endpackage
`default_nettype wire

// file: rtl/atc_top.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Acquisition kind picks refresh, averaging or envelope display.
// - Arithmetic off leaves acquisition kind to pick refresh, averaging or envelope; off after reset.
// - Envelope keeps per-point minimum and maximum across acquisitions.
// - Averaging blends current acquisition with earlier ones, weighted by averaging count.
// - One arithmetic setting serves all channels, no channel index.
// - Peak capture switch, automatic or off, selects peak decimation; off by default.
// - High resolution switch, automatic or off, selects averaging decimation; off default.
// - Single run captures a programmable waveform count, default one.
// - Averaging count clamped to 2..100000, default 2.
// - Averaging restart discards accumulated waveform and starts over.
// - Done flag is 0 until averaging count acquisitions gathered, then 1.
// - Automatic roll engages when timebase reaches roll limit; off by default.
// - Roll limit programmable per division, default 500e-3 s.
// - Interpolation linear, sinc curve or sample-hold; sinc curve by default.
// - Auto mode forces a trigger after a timeout; genuine trigger wins.
// - Normal mode captures only on genuine triggers; auto by default.
// - Trigger sources: four analog, external, line, two decoders, sixteen logic.
// - Trigger type selects edge, width, video, bus, pattern, line, transition, runt.
// - Holdoff blocks new genuine triggers until holdoff time passes, forced ones still fire; off by default.
// - Edge trigger on rising, falling or either slope; rising default.
// - Threshold per input: 1-4 analog channels, 5 external input.
module atc_top
    import atc_pkg::*;
#(
    parameter int AUTO_CYC = AUTO_TRIG_CYC
) (
    input  wire logic        i_sys_clk,
    input  wire logic        i_reset,
    input  wire logic        i_ce,
    input  wire logic        i_cfg_wr,
    input  wire atc_cfg_s    i_cfg,
    input  wire atc_smp_s    i_smp,
    input  wire logic        i_det_trig,
    input  wire logic        i_run,
    input  wire logic        i_single_run_command,
    input  wire logic        i_averaging_restart,
    input  wire logic [31:0] i_timebase_us,
    output var  atc_res_s    o_res,
    output logic             o_averaging_done_flag,
    output logic             o_roll,
    output atc_interp_e      o_interp,
    output logic             o_trig,
    output logic             o_forced,
    output logic             o_busy
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset || !i_ce);

    atc_cfg_s cfg_q, cfg_d;
    always_comb begin
        cfg_d = cfg_q;
        if (i_cfg_wr) begin
            cfg_d = i_cfg;
            if (i_cfg.averaging_count < AVG_CNT_MIN) begin
                cfg_d.averaging_count = AVG_CNT_MIN;
            end else if (i_cfg.averaging_count > AVG_CNT_MAX) begin
                cfg_d.averaging_count = AVG_CNT_MAX;
            end
            if (i_cfg.single_run_count == '0) begin
                cfg_d.single_run_count = SGL_CNT_RST;
            end
        end
    end
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            cfg_q <= CFG_RST;
        end else if (i_ce) begin
            cfg_q <= cfg_d;
        end
    end
    assign o_interp = cfg_q.interp_select;

    cfg_reset_a: assert property ($past(i_reset) |-> cfg_q.multi_acquisition_arith == arith_off
        && !cfg_q.peak_capture_switch && !cfg_q.high_res_switch) else $error("arith defaults wrong");
    avg_range_a: assert property (cfg_q.averaging_count inside {[AVG_CNT_MIN:AVG_CNT_MAX]})
        else $error("averaging count out of range");

    // Kind only matters while the shared all-channel arithmetic is off
    atc_arith_e arith;
    atc_dec_e   dec;
    always_comb begin
        arith = cfg_q.multi_acquisition_arith;
        if (arith == arith_off) begin
            unique case (cfg_q.acquisition_kind_select)
                kind_average:  arith = arith_avg;
                kind_envelope: arith = arith_env;
                default:       arith = arith_off;
            endcase
        end
        dec = cfg_q.peak_capture_switch ? dec_peak :
              (cfg_q.high_res_switch ? dec_hres : dec_sample);
    end

    // Two ADC samples per waveform point
    logic                         ph_q, ph_d, pt_v_q, pt_v_d;
    logic [NUM_CH-1:0][SMP_W-1:0] hold_q, hold_d, pt_lo_q, pt_lo_d, pt_hi_q, pt_hi_d;
    for (genvar c = 0; c < NUM_CH; c++) begin : g_dec
        always_comb begin
            logic [SMP_W:0] sum;
            sum = {1'b0, hold_q[c]} + {1'b0, i_smp.ch[c]};
            unique case (dec)
                dec_peak: begin
                    pt_lo_d[c] = (hold_q[c] < i_smp.ch[c]) ? hold_q[c] : i_smp.ch[c];
                    pt_hi_d[c] = (hold_q[c] < i_smp.ch[c]) ? i_smp.ch[c] : hold_q[c];
                end
                dec_hres: begin
                    pt_lo_d[c] = sum[SMP_W:1];
                    pt_hi_d[c] = sum[SMP_W:1];
                end
                default: begin
                    pt_lo_d[c] = hold_q[c];
                    pt_hi_d[c] = hold_q[c];
                end
            endcase
        end
    end
    always_comb begin
        ph_d   = i_smp.valid ? ~ph_q : ph_q;
        hold_d = (i_smp.valid && !ph_q) ? i_smp.ch : hold_q;
        pt_v_d = i_smp.valid && ph_q;
    end
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            ph_q    <= 1'b0;
            pt_v_q  <= 1'b0;
            hold_q  <= '0;
            pt_lo_q <= '0;
            pt_hi_q <= '0;
        end else if (i_ce) begin
            ph_q   <= ph_d;
            pt_v_q <= pt_v_d;
            hold_q <= hold_d;
            if (pt_v_d) begin
                pt_lo_q <= pt_lo_d;
                pt_hi_q <= pt_hi_d;
            end
        end
    end

    // Trigger path
    atc_state_e         st_q, st_d;
    logic [NUM_LVL-1:0] above;
    logic               lvl, prev_q, prev_d, src_ok, edge_hit, gen, forced, fire;
    logic [31:0]        ho_q, ho_d, auto_q, auto_d;
    for (genvar c = 0; c < NUM_CH; c++) begin : g_cmp
        assign above[c] = i_smp.ch[c] >= cfg_q.level[c];
    end
    assign above[NUM_LVL-1] = i_smp.ext >= cfg_q.level[NUM_LVL-1];
    always_comb begin
        unique case (cfg_q.trig_src)
            src_analog1:            lvl = above[0];
            src_analog2:            lvl = above[1];
            src_analog3:            lvl = above[2];
            src_analog4:            lvl = above[3];
            front_panel_trig_input: lvl = above[NUM_LVL-1];
            src_power_line:         lvl = i_smp.line;
            serial_decoder_one:     lvl = i_smp.sbus[0];
            serial_decoder_two:     lvl = i_smp.sbus[1];
            logic_channels:         lvl = i_smp.logic_in[cfg_q.logic_sel];
            default:                lvl = 1'b0;
        endcase
        src_ok = (cfg_q.trig_src != logic_channels) || (cfg_q.trig_type inside {tt_edge, tt_width, tt_pattern});
        unique case (cfg_q.slope)
            slope_rise:   edge_hit = lvl && !prev_q;
            slope_fall:   edge_hit = !lvl && prev_q;
            default:      edge_hit = lvl ^ prev_q;
        endcase
        edge_hit = edge_hit && i_smp.valid;
        prev_d   = i_smp.valid ? lvl : prev_q;
        // Other trigger types come from their own detectors
        gen = (st_q == st_armed) && src_ok && ((cfg_q.trig_type == tt_edge) ? edge_hit : i_det_trig)
              && !(cfg_q.holdoff_on && ho_q != '0);
        forced = (st_q == st_armed) && cfg_q.trig_auto && !gen && (auto_q == 32'(AUTO_CYC - 1));
        fire   = gen || forced;
        ho_d   = fire ? cfg_q.holdoff_cyc : ((ho_q != '0) ? ho_q - 32'h1 : ho_q);
        auto_d = ((st_q == st_armed) && !fire) ? auto_q + 32'h1 : '0;
    end
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            prev_q   <= 1'b0;
            ho_q     <= '0;
            auto_q   <= '0;
            o_trig   <= 1'b0;
            o_forced <= 1'b0;
        end else if (i_ce) begin
            prev_q   <= prev_d;
            ho_q     <= ho_d;
            auto_q   <= auto_d;
            o_trig   <= fire;
            o_forced <= forced;
        end
    end

    real_wins_a: assert property (gen |=> o_trig && !o_forced)
        else $error("genuine trigger lost to forced");
    normal_mode_a: assert property (o_forced |-> $past(cfg_q.trig_auto))
        else $error("forced trigger in normal mode");
    forced_time_a: assert property (o_forced |-> $past(auto_q) == 32'(AUTO_CYC - 1))
        else $error("forced trigger at wrong time");
    holdoff_gap_a: assert property (o_trig && !o_forced |-> $past(!cfg_q.holdoff_on || ho_q == '0))
        else $error("trigger inside holdoff");
    logic_src_a: assert property (o_trig && !o_forced && $past(cfg_q.trig_src) == logic_channels
        |-> $past(cfg_q.trig_type) inside {tt_edge, tt_width, tt_pattern}) else $error("logic source misuse");
    rise_edge_a: assert property (o_trig && !o_forced && $past(cfg_q.trig_type == tt_edge)
        && $past(cfg_q.slope == slope_rise) |-> $past(lvl && !prev_q)) else $error("edge not rising");
    trig_reset_a: assert property ($past(i_reset) |-> cfg_q.trig_auto && cfg_q.slope == slope_rise)
        else $error("trigger defaults wrong");

    // Acquisition sequencing
    logic [IDX_W-1:0] idx_q, idx_d;
    logic [15:0]      left_q, left_d;
    logic             single_q, single_d, wr, acq_end;
    always_comb begin
        st_d     = st_q;
        idx_d    = idx_q;
        left_d   = left_q;
        single_d = single_q;
        wr       = 1'b0;
        acq_end  = 1'b0;
        unique case (st_q)
            st_idle: begin
                if (i_single_run_command) begin
                    single_d = 1'b1;
                    left_d   = cfg_q.single_run_count;
                    st_d     = st_armed;
                end else if (i_run) begin
                    single_d = 1'b0;
                    st_d     = st_armed;
                end
            end
            st_armed: begin
                idx_d = '0;
                if (fire) begin
                    st_d = st_capt;
                end else if (!i_run && !single_q) begin
                    st_d = st_idle;
                end
            end
            st_capt: begin
                if (pt_v_q) begin
                    wr    = 1'b1;
                    idx_d = idx_q + 1'b1;
                    if (idx_q == IDX_W'(REC_LEN - 1)) begin
                        acq_end = 1'b1;
                        if (single_q) begin
                            left_d = left_q - 16'h1;
                            st_d   = (left_q == 16'h1) ? st_idle : st_armed;
                        end else begin
                            st_d = i_run ? st_armed : st_idle;
                        end
                    end
                end
            end
            default: st_d = st_idle;
        endcase
    end
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            st_q     <= st_idle;
            idx_q    <= '0;
            left_q   <= '0;
            single_q <= 1'b0;
            o_busy   <= 1'b0;
        end else if (i_ce) begin
            st_q     <= st_d;
            idx_q    <= idx_d;
            left_q   <= left_d;
            single_q <= single_d;
            o_busy   <= st_d != st_idle;
        end
    end

    // Multi-acquisition arithmetic
    logic [REC_LEN-1:0][NUM_CH-1:0][SMP_W-1:0] lo_mem_q, lo_mem_d, hi_mem_q, hi_mem_d;
    logic [NUM_CH-1:0][SMP_W-1:0]              nlo, nhi;
    logic [AVG_W-1:0]                          n_q, n_d, wt;
    logic [SH_W-1:0]                           sh;
    atc_res_s                                  res_d;
    logic                                      done_d;

    // Power-of-two weight keeps the blend divider-free; mean is approximate
    function automatic logic [SMP_W-1:0] avg_mix(input logic [SMP_W-1:0] old, input logic [SMP_W-1:0] nw,
                                                 input logic [SH_W-1:0] s);
        logic signed [SMP_W+1:0] diff;
        logic signed [SMP_W+1:0] acc;
        diff = $signed({2'b00, nw}) - $signed({2'b00, old});
        acc  = $signed({2'b00, old}) + (diff >>> s);
        return acc[SMP_W-1:0];
    endfunction

    always_comb begin
        wt = (n_q >= cfg_q.averaging_count) ? cfg_q.averaging_count : n_q + 1'b1;
        sh = '0;
        for (int b = 1; b < AVG_W; b++) begin
            if (wt[b]) begin
                sh = SH_W'(b);
            end
        end
    end
    for (genvar c = 0; c < NUM_CH; c++) begin : g_arith
        always_comb begin
            logic [SMP_W-1:0] olo;
            logic [SMP_W-1:0] ohi;
            olo    = lo_mem_q[idx_q][c];
            ohi    = hi_mem_q[idx_q][c];
            nlo[c] = pt_lo_q[c];
            nhi[c] = pt_hi_q[c];
            if (n_q != '0) begin
                unique case (arith)
                    arith_env: begin
                        nlo[c] = (olo < pt_lo_q[c]) ? olo : pt_lo_q[c];
                        nhi[c] = (ohi > pt_hi_q[c]) ? ohi : pt_hi_q[c];
                    end
                    arith_avg: begin
                        nlo[c] = avg_mix(olo, pt_lo_q[c], sh);
                        nhi[c] = avg_mix(ohi, pt_hi_q[c], sh);
                    end
                    default: begin
                    end
                endcase
            end
        end
    end
    always_comb begin
        lo_mem_d = lo_mem_q;
        hi_mem_d = hi_mem_q;
        if (wr) begin
            lo_mem_d[idx_q] = nlo;
            hi_mem_d[idx_q] = nhi;
        end
        res_d = '{valid: wr, idx: idx_q, lo: nlo, hi: nhi};
        // Completion in the restart cycle counts as the first of the new series
        if (i_averaging_restart) begin
            n_d = acq_end ? AVG_W'(1) : '0;
        end else if (acq_end && n_q < AVG_CNT_MAX) begin
            n_d = n_q + 1'b1;
        end else begin
            n_d = n_q;
        end
        done_d = n_d >= cfg_d.averaging_count;
    end
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            lo_mem_q              <= '0;
            hi_mem_q              <= '0;
            n_q                   <= '0;
            o_res                 <= '0;
            o_averaging_done_flag <= 1'b0;
            o_roll                <= 1'b0;
        end else if (i_ce) begin
            lo_mem_q              <= lo_mem_d;
            hi_mem_q              <= hi_mem_d;
            n_q                   <= n_d;
            o_res                 <= res_d;
            o_averaging_done_flag <= done_d;
            o_roll                <= cfg_q.auto_roll && (i_timebase_us >= cfg_q.scroll_timebase_limit);
        end
    end

    restart_clear_a: assert property (i_averaging_restart && !acq_end |=> !o_averaging_done_flag && n_q == '0)
        else $error("restart did not clear averaging");
    done_flag_a: assert property (o_averaging_done_flag == (n_q >= cfg_q.averaging_count))
        else $error("done flag mismatch");
    env_order_a: assert property (o_res.valid && $past(arith == arith_env) |-> o_res.lo[0] <= o_res.hi[0])
        else $error("envelope bounds crossed");
    roll_follow_a: assert property (!i_cfg_wr && cfg_q.auto_roll && i_timebase_us >= cfg_q.scroll_timebase_limit
        |=> o_roll) else $error("roll not engaged");
    roll_reset_a: assert property ($past(i_reset) |-> !cfg_q.auto_roll
        && cfg_q.scroll_timebase_limit == ROLL_LIM_RST_US) else $error("roll defaults wrong");

    forced_c: cover property (o_forced);
    done_c: cover property ($rose(o_averaging_done_flag));
    single_c: cover property (single_q && st_q == st_capt ##1 st_q == st_idle);
    roll_c: cover property ($rose(o_roll));
endmodule // atc_top
`default_nettype wire

// file: verif/atc_smp_model.sv
`timescale 1ns/1ps
`default_nettype none
module atc_smp_model
    import atc_pkg::*;
(
    input  wire logic             i_sys_clk,
    input  wire logic [SMP_W-1:0] i_val,
    output var  atc_smp_s         o_smp
);
    // Unwatched inputs keep moving so a stale value never looks steady
    initial o_smp = '0;
    always @(negedge i_sys_clk) begin
        o_smp.valid    <= 1'b1;
        o_smp.ch       <= {NUM_CH{i_val}};
        o_smp.ext      <= i_val;
        o_smp.line     <= ~o_smp.line;
        o_smp.sbus     <= o_smp.sbus + 2'h1;
        o_smp.logic_in <= ~o_smp.logic_in;
    end
endmodule // atc_smp_model
`default_nettype wire

// file: verif/tb_atc_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_atc_top
    import atc_pkg::*;
;
    logic             i_sys_clk = 1'b0;
    logic             i_reset = 1'b1;
    logic             i_cfg_wr = 1'b0;
    logic             i_single = 1'b0;
    logic             i_restart = 1'b0;
    logic [31:0]      i_timebase_us = '0;
    logic [31:0]      rng = 32'h4d6d;
    logic [SMP_W-1:0] val = '0;
    atc_cfg_s         cfg = CFG_RST;
    atc_smp_s         smp;
    atc_res_s         o_res;
    atc_interp_e      o_interp;
    logic             o_done, o_roll, o_trig, o_forced, o_busy;
    logic             ph = 1'b0;
    logic             det = 1'b0;
    logic [10:0]      exp_q[$];
    int               n_fail = 0, checks = 0, n_trig = 0, n_forced = 0;

    atc_smp_model atc_smp_model_inst (.i_sys_clk(i_sys_clk), .i_val(val), .o_smp(smp));
    // Short forced-trigger interval keeps auto runs brief
    atc_top #(.AUTO_CYC(20)) atc_top_inst (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_ce(1'b1),
        .i_cfg_wr(i_cfg_wr), .i_cfg(cfg), .i_smp(smp), .i_det_trig(det), .i_run(1'b0),
        .i_single_run_command(i_single), .i_averaging_restart(i_restart), .i_timebase_us(i_timebase_us),
        .o_res(o_res), .o_averaging_done_flag(o_done), .o_roll(o_roll), .o_interp(o_interp),
        .o_trig(o_trig), .o_forced(o_forced), .o_busy(o_busy));

    initial forever #5 i_sys_clk = ~i_sys_clk;

    // Sample pairing phase, free running from reset
    always @(posedge i_sys_clk) ph <= i_reset ? 1'b0 : ph ^ (smp.valid === 1'b1);

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want) begin
            n_fail++;
            $display("FAIL t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task automatic report_and_stop();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge i_sys_clk);
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask

    task automatic wait_idle();
        cyc(2);
        for (int i = 0; i <= 300; i++) begin
            if (o_busy === 1'b0) break;
            if (i == 300) begin
                n_fail++;
                report_and_stop();
            end
            cyc(1);
        end
    endtask

    task automatic push_pts(input logic [7:0] v);
        for (int i = 0; i < REC_LEN; i++) exp_q.push_back({i[IDX_W-1:0], v});
    endtask

    task automatic edge_run(input atc_slope_e s, input logic [7:0] v0, input logic [7:0] v1);
        cfg.slope = s;
        val <= v0;
        pulse(i_cfg_wr);
        pulse(i_single);
        cyc(30);
        chk(n_trig, 0);
        chk(o_busy, 1);
        // New level must open a point, else point 0 keeps the old sample
        if (ph !== 1'b1) cyc(1);
        val <= v1;
        push_pts(v1);
        wait_idle();
        chk(n_trig, 1);
        chk(exp_q.size(), 0);
        n_trig = 0;
        $display("test edge slope %0d done", s);
    endtask

    // Results stand one cycle, so look just after each rising edge
    always @(posedge i_sys_clk) begin
        #2;
        if (o_trig === 1'b1) n_trig++;
        if (o_forced === 1'b1) n_forced++;
        if (o_res.valid === 1'b1) begin
            if (exp_q.size() == 0) chk(1, 0);
            else chk({o_res.idx, o_res.lo[0], o_res.hi[3]}, {exp_q[0], exp_q[0][7:0]});
            if (exp_q.size() != 0) void'(exp_q.pop_front());
        end
    end

    initial begin
        cyc(5);
        i_reset = 1'b0;
        chk(o_interp, sinc_curve_interp);
        chk(o_done, 0);
        chk({o_roll, o_busy}, 0);
        cfg.auto_roll = 1'b1;
        cfg.scroll_timebase_limit = 32'h64;
        cfg.interp_select = sample_hold_interp;
        i_timebase_us = 32'h64;
        pulse(i_cfg_wr);
        cyc(2);
        chk(o_roll, 1);
        chk(o_interp, sample_hold_interp);
        i_timebase_us = 32'h63;
        cyc(2);
        chk(o_roll, 0);
        $display("test roll done");
        cfg.trig_auto = 1'b0;
        cfg.level[0] = 8'h80;
        rng = xs(rng);
        edge_run(slope_rise, 8'h00, rng[7:0] | 8'h80);
        rng = xs(rng);
        edge_run(slope_fall, rng[7:0] | 8'h80, 8'h00);
        rng = xs(rng);
        edge_run(slope_either, 8'h00, rng[7:0] | 8'h80);
        chk(o_done, 1);
        pulse(i_restart);
        cyc(2);
        chk(o_done, 0);
        cfg.trig_auto = 1'b1;
        cfg.acquisition_kind_select = kind_average;
        cfg.averaging_count = '0;
        // Level settles while idle so no genuine edge beats the forced one
        rng = xs(rng);
        val <= rng[7:0];
        pulse(i_cfg_wr);
        for (int k = 0; k < 2; k++) begin
            push_pts(val);
            pulse(i_single);
            wait_idle();
            chk(o_done, k);
            chk(n_forced, k + 1);
        end
        $display("test average done");
        n_trig = 0;
        cfg.trig_auto = 1'b0;
        cfg.trig_type = tt_width;
        pulse(i_cfg_wr);
        push_pts(val);
        pulse(i_single);
        cyc(30);
        chk(n_trig, 0);
        pulse(det);
        wait_idle();
        chk(n_trig, 1);
        chk(exp_q.size(), 0);
        $display("test detector done");
        report_and_stop();
    end
endmodule // tb_atc_top
`default_nettype wire
